// >>> rtl/pwcl_defines.svh
/*
 * Constants of the wake configuration loader: memory offsets, flag bit
 * positions, required block lengths, register offsets and pulse timing.
 * Assumes byte-wide configuration memory and a 25 MHz core clock.
 */
`ifndef PWCL_DEFINES_SVH
`define PWCL_DEFINES_SVH
// Configuration memory byte addresses.
`define PWCL_A_FLAG     9'h009
`define PWCL_A_FLT_LEN  9'h03d
`define PWCL_A_FLT_OFF  9'h03e
`define PWCL_A_LTM_LEN  9'h03f
`define PWCL_A_TB_LEN   9'h041
// Required block lengths in bytes, and the index of the last image byte.
`define PWCL_FLT_LEN    8'h14
`define PWCL_LTM_LEN    8'h18
`define PWCL_TB_LEN     8'h04
`define PWCL_IMG_LAST   5'h13
// Wake flag byte bit positions.
`define PWCL_B_EN       7
`define PWCL_B_PULSE    6
`define PWCL_B_LONG     5
`define PWCL_B_POL      4
`define PWCL_B_PP       3
`define PWCL_B_LINK     2
`define PWCL_B_PKT      1
`define PWCL_B_DA       0
// Register byte offsets.
`define PWCL_R_CTRL     12'h000
`define PWCL_R_WSTAT    12'h004
`define PWCL_R_FCFG     12'h008
`define PWCL_R_MASK0    12'h00c
`define PWCL_R_MASK1    12'h010
`define PWCL_R_MASK2    12'h014
`define PWCL_R_MASK3    12'h018
`define PWCL_R_FATTR    12'h01c
// Pulse timing.
`define PWCL_CLK_KHZ    25000
`define PWCL_SHORT_US   1500
`define PWCL_LONG_US    150000
// Cycles per microsecond first, so the long product stays inside 32 bits.
`define PWCL_SHORT_CYC  (`PWCL_SHORT_US * (`PWCL_CLK_KHZ / 1000))
`define PWCL_LONG_CYC   (`PWCL_LONG_US * (`PWCL_CLK_KHZ / 1000))
`endif

// >>> rtl/pwcl_pkg.sv
/*
 * Types of the wake configuration loader: loader states and the state
 * record. Assumes nothing of its surroundings.
 */
`default_nettype none
package pwcl_pkg;
    // Loader sequence states.
    typedef enum logic [2:0] {
        LD_FLAG, LD_LTM, LD_TB, LD_LEN, LD_OFF, LD_IMG, LD_DONE
    } pwcl_ld_t;
    // Pulse counter wide enough for the long pulse.
    typedef logic [21:0] pwcl_cnt_t;
    // Whole state of the loader.
    typedef struct packed {
        pwcl_ld_t     ld;
        logic [8:0]   addr;
        logic [4:0]   idx;
        logic [7:0]   flag;
        logic [7:0]   off;
        logic         done;
        logic         e_flt;
        logic         e_ltm;
        logic         e_tb;
        logic         flt_ok;
        logic [159:0] img;
        logic         pend;
        logic         pact;
        pwcl_cnt_t    cnt;
        logic         pin_out;
        logic         pin_oe;
        logic [31:0]  rdata;
    } pwcl_state_t;
endpackage
`default_nettype wire

// >>> rtl/pwcl_loader.sv
/*
 * Wake configuration loader: reads the wake flag byte and the wake
 * filter 0 image from configuration memory after reset, checks block
 * lengths, and drives the wake request pin from gated wake events.
 * Assumes a byte memory that acks each read once, and an APB master.
 */
// Behaviour
// - Master enable lets wake events assert request
// - Master enable clear: no wake signalling
// - Bit 6 picks level or pulse
// - Bit 5 picks 1.5 ms or 150 ms
// - Pulse timed from first event only
// - Bit 4 sets asserted polarity
// - Bit 3 picks open-drain or push-pull
// - Bit 2 enables link change source
// - Bit 1 enables packet source
// - Bit 0 enables address match source
// - Flag byte sets attribute defaults
// - Image loads filter config and masks
// - Filter image located at 3Dh, 3Eh
`include "pwcl_defines.svh"
`default_nettype none
module pwcl_loader #(
    parameter int unsigned SHORT_CYC = `PWCL_SHORT_CYC,
    parameter int unsigned LONG_CYC  = `PWCL_LONG_CYC
) (
    input  wire logic          core_clk,
    input  wire logic          arst_n,
    // APB slave.
    input  wire logic [11:0]   paddr,
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [31:0]   pwdata,
    output logic [31:0]        prdata,
    output logic               pready,
    output logic               pslverr,
    // Configuration memory read port.
    output logic               cfg_rd_req,
    output logic [8:0]         cfg_rd_addr,
    input  wire logic [7:0]    cfg_rd_data,
    input  wire logic          cfg_rd_ack,
    // Wake event pulses.
    input  wire logic          ev_wake_pin,
    input  wire logic          ev_packet,
    input  wire logic          ev_filter,
    input  wire logic          ev_addr_match,
    input  wire logic          ev_link_change,
    // Wake request pin, output and enable.
    output logic               wake_request_pin_o,
    output logic               wake_request_pin_oe,
    // Loaded filter and attribute values.
    output logic [31:0]        wake_filter_config,
    output logic [127:0]       wake_filter_byte_mask,
    output logic [7:0]         flag_attribute_defaults,
    output logic               load_done
);
    // Registered and next state.
    pwcl_pkg::pwcl_state_t s, n;
    // Master enable, gated wake event, pin terms, APB decodes and pulse target.
    logic                  en;
    logic                  ev;
    logic                  act;
    logic                  lvl;
    logic                  acc;
    logic                  wr_ctrl;
    logic                  wr_wstat;
    logic                  mapped;
    pwcl_pkg::pwcl_cnt_t   tgt;

    // Access phase of a transfer; the slave never inserts wait states.
    assign acc      = psel && penable;
    assign wr_ctrl  = acc && pwrite && (paddr == `PWCL_R_CTRL);
    assign wr_wstat = acc && pwrite && (paddr == `PWCL_R_WSTAT);
    assign mapped   = (paddr <= `PWCL_R_FATTR) && (paddr[1:0] == 2'h0);
    assign pready   = 1'b1;
    assign pslverr  = acc && !mapped;

    // Target length of a pulse in cycles.
    // pulse length select
    assign tgt = s.flag[`PWCL_B_LONG] ? pwcl_pkg::pwcl_cnt_t'(LONG_CYC)
                                      : pwcl_pkg::pwcl_cnt_t'(SHORT_CYC);

    // Master enable gates everything else in the byte.
    // master enable gate
    assign en = s.flag[`PWCL_B_EN];

    // Gated wake event; pin and filter events need only the master enable.
    // wake source gating
    assign ev = en && (ev_wake_pin || ev_filter
                || (ev_packet && s.flag[`PWCL_B_PKT])
                || (ev_addr_match && s.flag[`PWCL_B_DA])
                || (ev_link_change && s.flag[`PWCL_B_LINK]));

    // Next state: loader sequence, wake timing and register reads.
    always_comb begin
        n = s;
        act = 1'b0;
        lvl = 1'b0;
        // Loader walks the memory one byte per acknowledge.
        case (s.ld)
            pwcl_pkg::LD_FLAG: begin
                if (cfg_rd_ack) begin
                    n.flag = cfg_rd_data;
                    n.ld = pwcl_pkg::LD_LTM;
                end
            end
            pwcl_pkg::LD_LTM: begin
                if (cfg_rd_ack) begin
                    n.e_ltm = (cfg_rd_data != 8'h00) && (cfg_rd_data != `PWCL_LTM_LEN);
                    n.ld = pwcl_pkg::LD_TB;
                end
            end
            pwcl_pkg::LD_TB: begin
                if (cfg_rd_ack) begin
                    n.e_tb = (cfg_rd_data != 8'h00) && (cfg_rd_data != `PWCL_TB_LEN);
                    n.ld = pwcl_pkg::LD_LEN;
                end
            end
            pwcl_pkg::LD_LEN: begin
                if (cfg_rd_ack) begin
                    if (cfg_rd_data == `PWCL_FLT_LEN) begin
                        n.flt_ok = 1'b1;
                        n.ld = pwcl_pkg::LD_OFF;
                    end else begin
                        // Absent or malformed image: keep filter at reset.
                        n.e_flt = (cfg_rd_data != 8'h00);
                        n.ld = pwcl_pkg::LD_DONE;
                    end
                end
            end
            pwcl_pkg::LD_OFF: begin
                if (cfg_rd_ack) begin
                    n.off = cfg_rd_data;
                    n.idx = 5'h00;
                    n.ld = pwcl_pkg::LD_IMG;
                end
            end
            pwcl_pkg::LD_IMG: begin
                if (cfg_rd_ack) begin
                    n.img[8*s.idx +: 8] = cfg_rd_data;
                    if (s.idx == `PWCL_IMG_LAST) begin
                        n.ld = pwcl_pkg::LD_DONE;
                    end else begin
                        n.idx = s.idx + 5'h01;
                    end
                end
            end
            pwcl_pkg::LD_DONE: begin
                n.done = 1'b1;
            end
            default: begin
                n.ld = pwcl_pkg::LD_DONE;
            end
        endcase
        // Software reload starts over and silences the pin until the flag byte is read again.
        if (wr_ctrl && pwdata[0]) begin
            n.ld = pwcl_pkg::LD_FLAG;
            n.flag = 8'h00;
            n.done = 1'b0;
            n.e_flt = 1'b0;
            n.e_ltm = 1'b0;
            n.e_tb = 1'b0;
            n.flt_ok = 1'b0;
            n.img = '0;
        end
        // Address of the next read follows the next state.
        // filter image location
        case (n.ld)
            pwcl_pkg::LD_FLAG: n.addr = `PWCL_A_FLAG;
            pwcl_pkg::LD_LTM:  n.addr = `PWCL_A_LTM_LEN;
            pwcl_pkg::LD_TB:   n.addr = `PWCL_A_TB_LEN;
            pwcl_pkg::LD_LEN:  n.addr = `PWCL_A_FLT_LEN;
            pwcl_pkg::LD_OFF:  n.addr = `PWCL_A_FLT_OFF;
            pwcl_pkg::LD_IMG:  n.addr = {n.off, 1'b0} + {4'h0, n.idx};
            default:           n.addr = s.addr;
        endcase
        // Pending status; a new event beats a clear in the same cycle.
        // pending held until cleared
        n.pend = ev || (s.pend && !(wr_wstat && pwdata[0]));
        if (!en) begin
            n.pend = 1'b0;
        end
        // Pulse timer; events during a pulse are ignored.
        // no extend or restart
        if (en && s.flag[`PWCL_B_PULSE]) begin
            if (s.pact) begin
                n.cnt = s.cnt + 22'h000001;
                if (s.cnt == tgt - 22'h000001) begin
                    n.pact = 1'b0;
                    n.cnt = '0;
                end
            end else if (ev) begin
                n.pact = 1'b1;
                n.cnt = '0;
            end
        end else begin
            n.pact = 1'b0;
            n.cnt = '0;
        end
        // Asserted state picks the pin level from the polarity bit.
        // level or pulse form
        act = n.flag[`PWCL_B_PULSE] ? n.pact : n.pend;
        lvl = act ? n.flag[`PWCL_B_POL] : !n.flag[`PWCL_B_POL];
        n.pin_out = lvl;
        // Open drain only drives a low; push-pull drives both levels while the master enable is set.
        // driver type
        n.pin_oe = n.flag[`PWCL_B_EN] && (n.flag[`PWCL_B_PP] || !lvl);
        // Read data is captured in the setup phase so it comes from a flop.
        if (psel && !penable) begin
            case (paddr)
                `PWCL_R_CTRL: n.rdata = {18'h0, s.pact, s.flt_ok, s.e_tb, s.e_ltm,
                                         s.e_flt, s.done, s.flag};
                `PWCL_R_WSTAT: n.rdata = {31'h0, s.pend};
                `PWCL_R_FCFG:  n.rdata = s.img[31:0];
                `PWCL_R_MASK0: n.rdata = s.img[63:32];
                `PWCL_R_MASK1: n.rdata = s.img[95:64];
                `PWCL_R_MASK2: n.rdata = s.img[127:96];
                `PWCL_R_MASK3: n.rdata = s.img[159:128];
                `PWCL_R_FATTR: n.rdata = {24'h0, s.flag};
                default:       n.rdata = 32'h0;
            endcase
        end
    end

    // State register; a clean start reads the flag byte first.
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            s <= '0;
            s.ld <= pwcl_pkg::LD_FLAG;
            s.addr <= `PWCL_A_FLAG;
        end else begin
            s <= n;
        end
    end

    // Outputs straight from the state register.
    assign prdata = s.rdata;
    assign cfg_rd_req = (s.ld != pwcl_pkg::LD_DONE);
    assign cfg_rd_addr = s.addr;
    assign wake_request_pin_o = s.pin_out;
    assign wake_request_pin_oe = s.pin_oe;
    assign wake_filter_config = s.img[31:0];
    assign wake_filter_byte_mask = s.img[159:32];
    assign flag_attribute_defaults = s.flag;
    assign load_done = s.done;

    // Helper for the checks: length of the current pulse so far.
    pwcl_pkg::pwcl_cnt_t alen_q;
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            alen_q <= '0;
        end else begin
            alen_q <= s.pact ? alen_q + 22'h000001 : '0;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);

    a_master_off_quiet: assert property (!en |-> !wake_request_pin_oe)
        else $error("pin driven with master enable clear");
    a_pulse_exact_len: assert property ($fell(s.pact) |-> alen_q == $past(tgt))
        else $error("pulse length differs from target");
    a_pulse_no_restart: assert property (
        s.pact && ev && s.cnt != tgt - 22'h000001 |=> s.cnt == $past(s.cnt) + 22'h000001)
        else $error("pulse restarted by a later event");
    a_level_holds_pend: assert property (
        en && !s.flag[`PWCL_B_PULSE] && ev && !wr_ctrl ##1 !wr_wstat [*2]
        |-> s.pend)
        else $error("level dropped without a clear");
    a_pulse_starts: assert property (
        en && s.flag[`PWCL_B_PULSE] && !s.pact && ev && !wr_ctrl |=> s.pact)
        else $error("event did not start a pulse");
    a_active_polarity: assert property (
        en && s.pend && !s.flag[`PWCL_B_PULSE] && !wr_ctrl && !wr_wstat
        |=> wake_request_pin_o == $past(s.flag[`PWCL_B_POL]))
        else $error("asserted level has wrong polarity");
    a_open_drain_high: assert property (
        !s.flag[`PWCL_B_PP] && wake_request_pin_o |-> !wake_request_pin_oe)
        else $error("open drain pin drives high");
    a_link_gated: assert property (
        !s.flag[`PWCL_B_LINK] && ev_link_change && !ev_wake_pin && !ev_filter
        && !ev_packet && !ev_addr_match && !s.pend |=> !s.pend)
        else $error("link change woke while disabled");
    a_packet_gated: assert property (
        !s.flag[`PWCL_B_PKT] && ev_packet && !ev_wake_pin && !ev_filter
        && !ev_link_change && !ev_addr_match && !s.pend |=> !s.pend)
        else $error("packet woke while disabled");
    a_addr_gated: assert property (
        !s.flag[`PWCL_B_DA] && ev_addr_match && !ev_wake_pin && !ev_filter
        && !ev_link_change && !ev_packet && !s.pend |=> !s.pend)
        else $error("address match woke while disabled");
    a_event_wakes: assert property (en && ev_wake_pin && !wr_ctrl |=> s.pend)
        else $error("wake pin event not recorded");
    a_filter_load: assert property (
        s.ld == pwcl_pkg::LD_IMG && cfg_rd_ack && s.idx == 5'h00 && !wr_ctrl
        |=> wake_filter_config[7:0] == $past(cfg_rd_data))
        else $error("filter config byte not loaded");
    a_len_addr: assert property (
        s.ld == pwcl_pkg::LD_LEN |-> cfg_rd_addr == `PWCL_A_FLT_LEN)
        else $error("filter length read at wrong address");
endmodule
`default_nettype wire

// >>> sim/pwcl_mem_model.sv
/*
 * Byte-wide configuration memory that answers the loader's read port.
 * Assumes the loader holds request and address until the acknowledge.
 */
`default_nettype none
module pwcl_mem_model (
    input  wire logic       core_clk,
    input  wire logic       arst_n,
    input  wire logic       cfg_rd_req,
    input  wire logic [8:0] cfg_rd_addr,
    output logic      [7:0] cfg_rd_data,
    output logic            cfg_rd_ack
);
    timeunit 1ns;
    timeprecision 1ps;
    // Contents, filled by the bench before each load.
    logic [7:0]  mem_q [0:511];
    // Wait cycles before each answer; zero answers at once.
    int unsigned lat = 2;
    // Cycles waited so far for the current request.
    int unsigned wait_q;
    // One answer per request. Data outside the ack cycle is inverted so a
    // stale byte can never pass for a fresh one.
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            cfg_rd_ack  <= 1'b0;
            cfg_rd_data <= 8'h00;
            wait_q      <= 0;
        end else if (cfg_rd_ack) begin
            cfg_rd_ack  <= 1'b0;
            cfg_rd_data <= ~cfg_rd_data;
        end else if (cfg_rd_req && wait_q >= lat) begin
            cfg_rd_ack  <= 1'b1;
            cfg_rd_data <= mem_q[cfg_rd_addr];
            wait_q      <= 0;
        end else if (cfg_rd_req) begin
            wait_q <= wait_q + 1;
        end
    end
endmodule
`default_nettype wire

// >>> sim/tb.sv
/*
 * Self-checking bench of the wake configuration loader.
 * Assumes the APB slave and the memory model in pwcl_mem_model.sv.
 */
`include "pwcl_defines.svh"
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    // Shortened pulse lengths handed to the design.
    localparam int SHORT = 5;
    localparam int LONG  = 12;
    // Event vector: wake pin, packet, filter, address match, link.
    localparam logic [4:0] S_PIN = 5'h10;
    localparam logic [4:0] S_PKT = 5'h08;
    localparam logic [4:0] S_FLT = 5'h04;
    localparam logic [4:0] S_DA  = 5'h02;
    localparam logic [4:0] S_LNK = 5'h01;
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin n_mismatch++; \
    $display("MISMATCH %s expected %0h seen %0h", nm, e, g); end end
    logic         core_clk, arst_n, psel, penable, pwrite;
    logic [11:0]  paddr;
    logic [31:0]  pwdata, prdata, wake_filter_config;
    logic         pready, pslverr, cfg_rd_req, cfg_rd_ack, pin_o, pin_oe, load_done;
    logic [8:0]   cfg_rd_addr;
    logic [7:0]   cfg_rd_data, flag_attribute_defaults;
    logic [127:0] wake_filter_byte_mask;
    logic [4:0]   evs;
    int           n_mismatch, samples_checked, cycles;
    wire logic    pin_lvl;
    // The line has a pull-up, so a released open-drain pin reads high.
    assign pin_lvl = pin_oe ? pin_o : 1'b1;

    pwcl_loader #(.SHORT_CYC(SHORT), .LONG_CYC(LONG)) uut (
        .core_clk(core_clk), .arst_n(arst_n), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .cfg_rd_req(cfg_rd_req),
        .cfg_rd_addr(cfg_rd_addr), .cfg_rd_data(cfg_rd_data), .cfg_rd_ack(cfg_rd_ack),
        .ev_wake_pin(evs[4]), .ev_packet(evs[3]), .ev_filter(evs[2]),
        .ev_addr_match(evs[1]), .ev_link_change(evs[0]),
        .wake_request_pin_o(pin_o), .wake_request_pin_oe(pin_oe),
        .wake_filter_config(wake_filter_config),
        .wake_filter_byte_mask(wake_filter_byte_mask),
        .flag_attribute_defaults(flag_attribute_defaults), .load_done(load_done));
    pwcl_mem_model mem (
        .core_clk(core_clk), .arst_n(arst_n), .cfg_rd_req(cfg_rd_req),
        .cfg_rd_addr(cfg_rd_addr), .cfg_rd_data(cfg_rd_data), .cfg_rd_ack(cfg_rd_ack));

    // Clock at 25 MHz.
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    // A hang is cut short far beyond the expected run length.
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            give_verdict();
        end
    end
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // Drive the event vector at an edge, then let that edge settle.
    task automatic step(input logic [4:0] v);
        @(posedge core_clk);
        evs <= v;
        #1;
    endtask
    // One APB transfer; the request is held until pready is seen high.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic err);
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        while (pready !== 1'b1) @(posedge core_clk);
        r = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wait_done();
        int k;
        for (k = 0; k < 300 && load_done !== 1'b1; k++) @(posedge core_clk);
        #1;
        `CHK("load done", 1'b1, load_done)
        `CHK("read idle", 1'b0, cfg_rd_req)
    endtask
    // Expected line level and enable for an asserted or idle request.
    task automatic pin_is(input logic act, input logic [7:0] f);
        logic lvl;
        lvl = act ? f[4] : !f[4];
        `CHK("pin level", lvl, pin_lvl)
        `CHK("pin enable", f[3] | !lvl, pin_oe)
    endtask
    // Restart the load with a new flag byte.
    task automatic load_cfg(input logic [7:0] f);
        logic [31:0] r;
        logic e;
        mem.mem_q[9] = f;
        apb(1'b1, `PWCL_R_CTRL, 32'h0000_0001, r, e);
        repeat (2) @(posedge core_clk);
        wait_done();
        `CHK("attr defaults", f, flag_attribute_defaults)
    endtask
    task automatic t_load();
        logic [127:0] m;
        logic [31:0] r;
        logic e;
        for (int i = 0; i < 16; i++) m[8*i+:8] = 8'(164 + i);
        `CHK("filter config", 32'ha3a2a1a0, wake_filter_config)
        `CHK("filter masks", m, wake_filter_byte_mask)
        `CHK("attr defaults", 8'hda, flag_attribute_defaults)
        apb(1'b0, `PWCL_R_FCFG, 32'h0, r, e);
        `CHK("config reg", 32'ha3a2a1a0, r)
        apb(1'b0, `PWCL_R_MASK3, 32'h0, r, e);
        `CHK("mask3 reg", m[127:96], r)
        apb(1'b0, 12'h020, 32'h0, r, e);
        `CHK("unmapped error", 1'b1, e)
        apb(1'b0, `PWCL_R_CTRL, 32'h0, r, e);
        `CHK("ctrl status", 32'h0000_11da, r)
    endtask
    // Pulse held exactly n cycles; an event inside it changes nothing.
    task automatic t_pulse(input logic [7:0] f, input logic [4:0] src, input int n);
        load_cfg(f);
        step(src);
        for (int k = 1; k <= n + 2; k++) begin
            step((k == 2) ? src : 5'h00);
            pin_is(k <= n, f);
        end
    endtask
    // Level held until the pending status is cleared.
    task automatic t_level();
        logic [31:0] r;
        logic e;
        load_cfg(8'h84);
        step(S_LNK);
        step(5'h00);
        pin_is(1'b1, 8'h84);
        repeat (10) step(5'h00);
        pin_is(1'b1, 8'h84);
        apb(1'b0, `PWCL_R_WSTAT, 32'h0, r, e);
        `CHK("pending", 1'b1, r[0])
        apb(1'b1, `PWCL_R_WSTAT, 32'h0000_0001, r, e);
        repeat (2) step(5'h00);
        pin_is(1'b0, 8'h84);
    endtask
    // Disabled sources and a cleared master enable never signal.
    task automatic t_blocked();
        load_cfg(8'h84);
        step(S_PKT);
        step(S_DA);
        repeat (3) step(5'h00);
        pin_is(1'b0, 8'h84);
        load_cfg(8'h7f);
        step(5'h1f);
        repeat (3) step(5'h00);
        `CHK("off enable", 1'b0, pin_oe)
        `CHK("off level", 1'b1, pin_lvl)
    endtask
    // Wrong block lengths are flagged and the filter image is skipped.
    task automatic t_lengths();
        logic [31:0] r;
        logic e;
        mem.mem_q[9'h03d] = 8'h10;
        mem.mem_q[9'h03f] = 8'h10;
        mem.mem_q[9'h041] = 8'h08;
        load_cfg(8'h83);
        `CHK("skipped filter", 32'h0, wake_filter_config)
        apb(1'b0, `PWCL_R_CTRL, 32'h0, r, e);
        `CHK("length errors", 32'h0000_0f83, r)
        step(S_LNK);
        repeat (3) step(5'h00);
        pin_is(1'b0, 8'h83);
    endtask

    initial begin
        n_mismatch = 0;
        samples_checked = 0;
        cycles = 0;
        arst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        evs = 5'h00;
        for (int i = 0; i < 512; i++) mem.mem_q[i] = 8'h00;
        mem.mem_q[9] = 8'hda;
        mem.mem_q[9'h03d] = 8'h14;
        mem.mem_q[9'h03e] = 8'h30;
        mem.mem_q[9'h03f] = 8'h18;
        mem.mem_q[9'h041] = 8'h04;
        mem.mem_q[9'h02f] = 8'h00;
        mem.mem_q[9'h033] = 8'h00;
        for (int i = 0; i < 20; i++) mem.mem_q[96 + i] = 8'(160 + i);
        repeat (4) @(posedge core_clk);
        arst_n <= 1'b1;
        wait_done();
        t_load();
        mem.lat = 0;
        t_pulse(8'hda, S_PKT, SHORT);
        t_pulse(8'he0, S_FLT, LONG);
        t_pulse(8'hd9, S_DA, SHORT);
        t_pulse(8'hf0, S_PIN, LONG);
        t_level();
        t_blocked();
        t_lengths();
        give_verdict();
    end
endmodule
`default_nettype wire
